// File: hdl/acr_consts.vh
// Constants for the converter control block: offsets, bit positions,
// reset values and cycle counts. Assumes byte addressing on an 8-bit paddr.
`ifndef ACR_CONSTS_VH
`define ACR_CONSTS_VH
`define ACR_OFF_SEL 8'h00
`define ACR_OFF_CTLA 8'h04
`define ACR_OFF_RESL 8'h08
`define ACR_OFF_RESH 8'h0c
`define ACR_OFF_CTLB 8'h10
`define ACR_OFF_ISTAT 8'h14
`define ACR_OFF_IMASK 8'h18
`define ACR_SEL_LADJ 5
`define ACR_CTLA_EN 7
`define ACR_CTLA_START 6
`define ACR_CTLA_ATE 5
`define ACR_CTLA_FLAG 4
`define ACR_CTLA_IE 3
`define ACR_SEL_RESET 8'h00
`define ACR_CTLA_RESET 8'h00
`define ACR_CTLB_RESET 3'h0
`define ACR_REF_EXT 2'h0
`define ACR_REF_SUPPLY 2'h1
`define ACR_REF_RSVD 2'h2
`define ACR_REF_INT 2'h3
`define ACR_CYC_FIRST 5'h19
`define ACR_CYC_NORMAL 5'h0d
`define ACR_CYC_SAMPLE 5'h03
`define ACR_SAR_BITS 5'h0a
`define ACR_TSEL_FREE 3'h0
`define ACR_IRQ_DONE 0
`define ACR_IRQ_ABORT 1
`endif

// File: hdl/acr_edge.v
// Rising-edge detector for one trigger line.
// Assumes the line is synchronous to clk.
`default_nettype none
module acr_edge (
    // Clock, reset, enable
    input wire clk,
    input wire rst,
    input wire ce,
    // Line and its edge
    input wire din,
    output wire rise
);
    reg prev_reg;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_reg <= 1'b0;
        end else if (ce) begin
            prev_reg <= din;
        end
    end

    // Gated by ce so a frozen block sees no edge
    assign rise = ce & din & ~prev_reg;
endmodule
`default_nettype wire

// File: hdl/acr_ctrl.v
// Digital control of a 10-bit successive-approximation converter:
// APB registers, channel and reference selection, start and auto-trigger,
// result coding, alignment and read locking, completion interrupt.
// Assumes all inputs synchronous to clk and an analogue core that answers
// each trial code on core_dac with cmp_in in the same cycle.
//
// Notes on behaviour
// RULE1 - Single-ended results are unsigned codes 0x000 to 0x3ff.
// RULE2 - Differential results are two's complement, 0x200 to 0x1ff, saturating.
// RULE3 - Result is readable from low and high bytes once flag is set.
// RULE4 - Reference field bits 7:6: external, supply, reserved, internal.
// RULE5 - Reference and channel changes apply only after the running conversion.
// RULE6 - Left-adjust bit 5 changes the result view at once.
// RULE7 - Channel field selects single, differential, bandgap or ground inputs.
// RULE8 - Enable bit turns converter on; clearing it aborts a conversion.
// RULE9 - Software writes start for each single conversion, first only otherwise.
// RULE10 - First conversion after enabling takes 25 cycles, later ones 13.
// RULE11 - Start bit reads one while busy; writing zero does nothing.
// RULE12 - With auto-trigger set, each rising trigger edge starts a conversion; here edges while busy are ignored, except in the last busy cycle.
// RULE13 - Selection register resets to zero.
// RULE14 - Flag sets on completion; cleared by vector or writing one.
// RULE15 - Reading the low byte blocks updates until the high byte is read.
// RULE16 - Left: bits 9:2 high, 1:0 on top of low; right: 9:8 low of high.
// RULE17 - Reserved reference code is stored but keeps internal reference off.
`include "acr_consts.vh"
`default_nettype none
module acr_ctrl (
    // Clock, reset, enable
    input wire clk,
    input wire rst,
    input wire ce,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Trigger sources 1 to 7 and interrupt vector acknowledge
    input wire [6:0] trig_src,
    input wire vector_ack,
    // Analogue core
    input wire cmp_in,
    output wire core_en,
    output wire core_sample,
    output wire [9:0] core_dac,
    output wire ref_supply_on,
    output wire ref_internal_on,
    output wire diff_mode,
    output wire [2:0] pos_input,
    output wire [1:0] neg_input,
    output wire sel_bandgap,
    output wire sel_ground,
    // Interrupt
    output wire irq
);
    localparam ST_OFF = 3'b001;
    localparam ST_IDLE = 3'b010;
    localparam ST_CONV = 3'b100;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [7:0] sel_reg;
    reg en_reg;
    reg ate_reg;
    reg flag_reg;
    reg ie_reg;
    reg [2:0] presc_reg;
    reg [2:0] tsel_reg;
    reg [1:0] istat_reg;
    reg [1:0] imask_reg;
    reg [9:0] result_reg;
    reg lock_reg;
    reg first_reg;
    reg [4:0] cnt_reg;
    reg [4:0] len_reg;
    reg [9:0] sar_reg;
    reg [1:0] act_ref_reg;
    reg [4:0] act_chan_reg;
    reg [31:0] prdata_reg;
    reg [31:0] rd_mux;

    // Bus decode
    wire hit_sel = paddr == `ACR_OFF_SEL;
    wire hit_ctla = paddr == `ACR_OFF_CTLA;
    wire hit_resl = paddr == `ACR_OFF_RESL;
    wire hit_resh = paddr == `ACR_OFF_RESH;
    wire hit_ctlb = paddr == `ACR_OFF_CTLB;
    wire hit_istat = paddr == `ACR_OFF_ISTAT;
    wire hit_imask = paddr == `ACR_OFF_IMASK;
    wire hit_any = hit_sel | hit_ctla | hit_resl | hit_resh | hit_ctlb | hit_istat | hit_imask;
    wire acc = psel & penable & ce;
    wire wr = acc & pwrite & hit_any;
    wire rd = acc & ~pwrite & hit_any;
    wire setup = psel & ~penable & ce;
    wire wr_ctla = wr & hit_ctla;

    // Read data is captured at setup, so the access phase needs no wait state.
    // A frozen block stretches the access phase instead of losing it
    assign pready = ce;
    assign pslverr = psel & penable & ~hit_any;
    assign prdata = prdata_reg;

    wire busy = state_reg == ST_CONV;
    wire en_next = wr_ctla ? pwdata[`ACR_CTLA_EN] : en_reg;

    // Successive approximation datapath
    wire [4:0] bit_idx = len_reg - 5'h01 - cnt_reg;
    wire in_bits = cnt_reg >= (len_reg - `ACR_SAR_BITS);
    wire [9:0] bit_mask = in_bits ? (10'h001 << bit_idx[3:0]) : 10'h000;
    wire [9:0] trial = sar_reg | bit_mask;
    wire [9:0] sar_new = cmp_in ? trial : sar_reg;
    wire done = busy & ce & (cnt_reg == len_reg - 5'h01);

    // Channel decode from the applied selection
    wire chan_na = act_chan_reg[4:3] == 2'b01;
    wire chan_fix = act_chan_reg[4:1] == 4'b1111;
    assign diff_mode = act_chan_reg[4] & ~chan_fix; // see RULE7
    assign pos_input = act_chan_reg[2:0]; // see RULE7
    assign neg_input = diff_mode ? (act_chan_reg[3] ? 2'h2 : 2'h1) : 2'h0; // see RULE7
    assign sel_bandgap = act_chan_reg == 5'h1e; // see RULE7
    // Unused codes park the converter on ground
    assign sel_ground = (act_chan_reg == 5'h1f) | chan_na; // see RULE7

    // Offset binary from the SAR turns into two's complement by flipping the top bit;
    // full positive input leaves all ones, which saturates at 0x1ff
    wire [9:0] conv_code = diff_mode ? {~sar_new[9], sar_new[8:0]} : sar_new; // see RULE1 see RULE2

    // Reserved code behaves as external reference
    assign ref_supply_on = act_ref_reg == `ACR_REF_SUPPLY; // see RULE4 see RULE17
    assign ref_internal_on = act_ref_reg == `ACR_REF_INT; // see RULE4 see RULE17

    assign core_en = en_reg;
    assign core_dac = trial;
    assign core_sample = busy & ~in_bits & (cnt_reg >= len_reg - `ACR_SAR_BITS - `ACR_CYC_SAMPLE);

    // Trigger selection; a switch of source may itself make an edge
    wire [7:0] trig_vec = {trig_src, 1'b0};
    wire trig_sel = trig_vec[tsel_reg];
    wire trig_rise;

    acr_edge u_trig_edge (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .din(trig_sel),
        .rise(trig_rise)
    );

    wire free_run = tsel_reg == `ACR_TSEL_FREE;
    // Free running never uses the edge path, so switching to it makes no trigger
    wire auto_start = en_reg & ate_reg & (free_run ? done : trig_rise); // see RULE12
    wire sw_start = wr_ctla & pwdata[`ACR_CTLA_START]; // see RULE11 see RULE9
    wire go = (sw_start | auto_start) & en_next & (~busy | done);
    wire abort = busy & ce & ~en_next; // see RULE8
    wire first_go = first_reg | ~en_reg;

    // Result byte views follow the live left-adjust bit
    wire ladj = sel_reg[`ACR_SEL_LADJ];
    wire [7:0] res_low = ladj ? {result_reg[1:0], 6'h00} : result_reg[7:0]; // see RULE6 see RULE16
    wire [7:0] res_high = ladj ? result_reg[9:2] : {6'h00, result_reg[9:8]}; // see RULE6 see RULE16

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (go) begin
                    state_next = ST_CONV;
                end else if (en_next) begin
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (go) begin
                    state_next = ST_CONV;
                end else if (~en_next) begin
                    state_next = ST_OFF;
                end
            end
            ST_CONV: begin
                if (abort) begin
                    state_next = ST_OFF; // see RULE8
                end else if (done & ~go) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    always @* begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            hit_sel: rd_mux[7:0] = sel_reg;
            hit_ctla: rd_mux[7:0] = {en_reg, busy, ate_reg, flag_reg, ie_reg, presc_reg}; // see RULE11
            hit_resl: rd_mux[7:0] = res_low; // see RULE3
            hit_resh: rd_mux[7:0] = res_high; // see RULE3
            hit_ctlb: rd_mux[2:0] = tsel_reg;
            hit_istat: rd_mux[1:0] = istat_reg;
            hit_imask: rd_mux[1:0] = imask_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Registers written by software
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_reg <= `ACR_SEL_RESET; // see RULE13
            en_reg <= 1'b0;
            ate_reg <= 1'b0;
            ie_reg <= 1'b0;
            presc_reg <= 3'h0;
            tsel_reg <= `ACR_CTLB_RESET;
            imask_reg <= 2'h0;
            prdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            // Reserved reference code is stored as written
            if (wr & hit_sel) begin
                sel_reg <= pwdata[7:0]; // see RULE17
            end
            if (wr_ctla) begin
                en_reg <= pwdata[`ACR_CTLA_EN]; // see RULE8
                ate_reg <= pwdata[`ACR_CTLA_ATE];
                ie_reg <= pwdata[`ACR_CTLA_IE];
                presc_reg <= pwdata[2:0];
            end
            if (wr & hit_ctlb) begin
                tsel_reg <= pwdata[2:0];
            end
            if (wr & hit_imask) begin
                imask_reg <= pwdata[1:0];
            end
            if (setup) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    // Conversion engine
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_OFF;
            cnt_reg <= 5'h00;
            len_reg <= `ACR_CYC_NORMAL;
            sar_reg <= 10'h000;
            first_reg <= 1'b0;
            act_ref_reg <= `ACR_REF_EXT;
            act_chan_reg <= 5'h00;
        end else if (ce) begin
            state_reg <= state_next;
            // Selection is held while busy and picked up again at completion
            if (~busy | done) begin
                act_ref_reg <= sel_reg[7:6]; // see RULE5
                act_chan_reg <= sel_reg[4:0]; // see RULE5
            end
            if (wr_ctla & pwdata[`ACR_CTLA_EN] & ~en_reg) begin
                first_reg <= 1'b1;
            end
            if (go) begin
                cnt_reg <= 5'h00;
                sar_reg <= 10'h000;
                len_reg <= first_go ? `ACR_CYC_FIRST : `ACR_CYC_NORMAL; // see RULE10
                first_reg <= 1'b0;
            end else if (busy) begin
                cnt_reg <= cnt_reg + 5'h01;
                sar_reg <= sar_new;
            end
        end
    end

    // Result, read lock, completion flag and interrupt status
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            result_reg <= 10'h000;
            lock_reg <= 1'b0;
            flag_reg <= 1'b0;
            istat_reg <= 2'h0;
        end else if (ce) begin
            // A result finishing while locked is lost, as with a pending low read.
            // The low byte is captured at setup and the lock taken at access, so
            // a result landing between the two would split the bytes: drop it too.
            if (done & ~abort & ~lock_reg & ~(setup & ~pwrite & hit_resl)) begin
                result_reg <= conv_code; // see RULE15
            end
            if (rd & hit_resl) begin
                lock_reg <= 1'b1; // see RULE15
            end else if (rd & hit_resh) begin
                lock_reg <= 1'b0; // see RULE15
            end
            // Set wins over either clear
            if (done & ~abort) begin
                flag_reg <= 1'b1; // see RULE14
            end else if (vector_ack | (wr_ctla & pwdata[`ACR_CTLA_FLAG])) begin
                flag_reg <= 1'b0; // see RULE14
            end
            // A read clears only what its captured data showed; a later event survives
            istat_reg <= (istat_reg & ~((rd & hit_istat) ? prdata_reg[1:0] : 2'h0)) | {abort, done & ~abort};
        end
    end

    assign irq = |(istat_reg & imask_reg);
endmodule
`default_nettype wire

// File: tb/acr_ctrl_assertions.sv
// Port checker for the converter control block.
// Assumes ce stays high while conversions run.
`default_nettype none
module acr_ctrl_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Analogue core side
    input wire logic core_en,
    input wire logic core_sample,
    input wire logic [9:0] core_dac,
    input wire logic ref_supply_on,
    input wire logic ref_internal_on,
    input wire logic diff_mode,
    input wire logic [2:0] pos_input,
    input wire logic [1:0] neg_input,
    input wire logic sel_bandgap,
    input wire logic sel_ground
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence sample_phase;
        core_sample [*3] ##1 !core_sample;
    endsequence
    sequence bit_phase;
        !core_sample [*8];
    endsequence
    AST_EN_GATE: assert property (!core_en |-> !core_sample)
        else $error("sampling while disabled");
    AST_SAMPLE: assert property ($rose(core_sample) && core_en |-> sample_phase)
        else $error("sampling phase length wrong");
    AST_BIT_PHASE: assert property ($fell(core_sample) && core_en |-> bit_phase)
        else $error("bit phase cut short");
    AST_FIRST_TRIAL: assert property ($fell(core_sample) && core_en |-> core_dac == 10'h200)
        else $error("first trial code wrong");
    AST_REF_ONE: assert property (!(ref_supply_on && ref_internal_on))
        else $error("two references on");
    AST_SEL_HOLD: assert property (core_sample && $past(core_sample) |->
        $stable({ref_supply_on, ref_internal_on, diff_mode, pos_input, neg_input, sel_bandgap, sel_ground}))
        else $error("selection changed in conversion");
    AST_GROUP: assert property (sel_bandgap |-> !sel_ground && !diff_mode)
        else $error("bandgap decode clash");
    AST_DIFF_NEG: assert property (diff_mode |-> neg_input != 2'h0)
        else $error("differential without negative input");
endmodule
bind acr_ctrl acr_ctrl_assertions chk_u (.clk, .rst, .core_en, .core_sample, .core_dac, .ref_supply_on,
    .ref_internal_on, .diff_mode, .pos_input, .neg_input, .sel_bandgap, .sel_ground);
`default_nettype wire

// File: tb/acr_core_model.sv
// Behavioural analogue core: levels are fractions of the reference times 1024.
// Assumes the comparator answers the trial code in the same cycle.
`default_nettype none
module acr_core_model #(parameter logic [9:0] BG_LEVEL = 10'h1c0) (
    // Selection and trial code
    input wire logic [9:0] core_dac,
    input wire logic diff_mode,
    input wire logic [2:0] pos_input,
    input wire logic [1:0] neg_input,
    input wire logic sel_bandgap,
    input wire logic sel_ground,
    // Input levels, input 0 lowest
    input wire logic [79:0] vins,
    // Comparator
    output logic cmp_in
);
    logic [9:0] vp, vn, lvl;
    logic signed [10:0] dv;
    always_comb begin
        vp = vins[pos_input * 10 +: 10];
        vn = (neg_input == 2'h1) ? vins[19:10] : (neg_input == 2'h2) ? vins[29:20] : 10'h000;
        // Half scale for differential; offset binary so the SAR sees an unsigned level
        dv = ($signed({1'b0, vp}) - $signed({1'b0, vn})) >>> 1;
        lvl = sel_ground ? 10'h000 : sel_bandgap ? BG_LEVEL : diff_mode ? (dv[9:0] ^ 10'h200) : vp;
        cmp_in = core_dac <= lvl;
    end
endmodule
`default_nettype wire

// File: tb/acr_ctrl_tb.sv
// Register-level bench for the converter control block.
// Assumes a zero-wait APB slave and the core model on the far side.
`include "acr_consts.vh"
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin num_errors++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module acr_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [79:0] VINS = {10'h0, 10'h0, 10'h1ff, 10'h0, 10'h2a5, 10'h35f, 10'h0, 10'h3ff};
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, vector_ack = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, q;
    logic [6:0] trig_src = 7'h00;
    logic e;
    wire [31:0] prdata;
    wire pready, pslverr, cmp_in, core_en, core_sample, ref_supply_on, ref_internal_on;
    wire diff_mode, sel_bandgap, sel_ground, irq;
    wire [9:0] core_dac;
    wire [2:0] pos_input;
    wire [1:0] neg_input;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    // Selection, low byte, high byte, expected {supply, internal}
    logic [31:0] rows [6] = '{32'h03a50200, 32'h2340a900, 32'hfbc0e801, 32'h50ff0102, 32'h1f000000, 32'h9ec00100};
    always #20 clk = ~clk;
    acr_ctrl dut_u (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .trig_src, .vector_ack, .cmp_in, .core_en, .core_sample, .core_dac, .ref_supply_on, .ref_internal_on,
        .diff_mode, .pos_input, .neg_input, .sel_bandgap, .sel_ground, .irq);
    acr_core_model #(.BG_LEVEL(10'h1c0)) core_u (.core_dac, .diff_mode, .pos_input, .neg_input, .sel_bandgap,
        .sel_ground, .vins(VINS), .cmp_in);
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
        xfer(a, 1'b0, 32'h0);
        `CHK(nm, {24'h0, ex}, q)
    endtask
    // Busy is probed three cycles before the last busy cycle, done in the first cycle after it
    task automatic conv(input logic [7:0] c, input int n);
        wr(`ACR_OFF_CTLA, c);
        repeat (n) @(posedge clk);
        rd(`ACR_OFF_CTLA, (c & 8'he0) | 8'h40, "busy");
        @(posedge clk);
        rd(`ACR_OFF_CTLA, (c & 8'ha0) | 8'h10, "done");
    endtask
    task end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            end_of_test;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(`ACR_OFF_SEL, 8'h00, "sel reset");
        rd(`ACR_OFF_CTLA, 8'h00, "ctla reset");
        rd(8'h1c, 8'h00, "unmapped");
        `CHK("slverr", 1'b1, e)
        wr(`ACR_OFF_IMASK, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(`ACR_OFF_SEL, rows[i][31:24]);
            conv(8'hd0, i == 0 ? 20 : 8);
            rd(`ACR_OFF_RESL, rows[i][23:16], "result low");
            rd(`ACR_OFF_RESH, rows[i][15:8], "result high");
            `CHK("ref decode", rows[i][1:0], {ref_supply_on, ref_internal_on})
        end
        wr(`ACR_OFF_SEL, 8'hbe);
        rd(`ACR_OFF_RESL, 8'h00, "left low");
        rd(`ACR_OFF_RESH, 8'h70, "left high");
        wr(`ACR_OFF_SEL, 8'h03);
        wr(`ACR_OFF_CTLA, 8'hd0);
        wr(`ACR_OFF_SEL, 8'h05);
        repeat (12) @(posedge clk);
        rd(`ACR_OFF_RESL, 8'ha5, "old channel");
        `CHK("pos applied", 3'h5, pos_input)
        conv(8'hd0, 8);
        rd(`ACR_OFF_RESH, 8'h02, "locked high");
        `CHK("irq masked", 1'b0, irq)
        wr(`ACR_OFF_IMASK, 8'h03);
        `CHK("irq raised", 1'b1, irq)
        rd(`ACR_OFF_ISTAT, 8'h01, "status done");
        `CHK("irq cleared", 1'b0, irq)
        wr(`ACR_OFF_CTLA, 8'hd0);
        repeat (4) @(posedge clk);
        wr(`ACR_OFF_CTLA, 8'h00);
        rd(`ACR_OFF_CTLA, 8'h00, "aborted");
        `CHK("core off", 1'b0, core_en)
        `CHK("irq abort", 1'b1, irq)
        rd(`ACR_OFF_ISTAT, 8'h02, "status abort");
        wr(`ACR_OFF_CTLB, 8'h01);
        wr(`ACR_OFF_CTLA, 8'ha0);
        trig_src <= 7'h01;
        repeat (30) @(posedge clk);
        rd(`ACR_OFF_CTLA, 8'hb0, "auto done");
        vector_ack <= 1'b1;
        @(posedge clk);
        vector_ack <= 1'b0;
        rd(`ACR_OFF_CTLA, 8'ha0, "vector clear");
        end_of_test;
    end
endmodule
`default_nettype wire
